// ===== shared/pcg_map.svh
`ifndef PCG_MAP_SVH
`define PCG_MAP_SVH
// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define PCG_OFF_GATE 12'h000
`define PCG_OFF_SYSCTL 12'h004
`define PCG_OFF_SLEEP 12'h008
`define PCG_OFF_ANALOG 12'h00C
`define PCG_OFF_INDIS_A 12'h010
`define PCG_OFF_INDIS_B 12'h014
`define PCG_OFF_WAKE 12'h018
`define PCG_OFF_STATUS 12'h01C
`define PCG_NUM_REGS 8
// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define PCG_GATE_MASK 8'h1F
`define PCG_GATE_RST 8'h00
`define PCG_SYSCTL_TPD 0
`define PCG_ANA_CONV 0
`define PCG_ANA_CMP_DIS 1
`define PCG_ANA_CMP_REF 2
`define PCG_ANA_CMP_MUX 3
`define PCG_ANA_RST 4'h0
`define PCG_MODE_RST 3'h0
`define PCG_BYTE_RST 8'h00
// ----------------------------------------------------------------
// Sleep mode codes and fuse codes
// ----------------------------------------------------------------
`define PCG_MODE_IDLE 3'h0
`define PCG_MODE_NOISE 3'h1
`define PCG_MODE_PDOWN 3'h2
`define PCG_MODE_PSAVE 3'h3
`define PCG_MODE_STANDBY 3'h6
`define PCG_BOD_OFF 3'h7
`endif

// ===== shared/pcg_pkg.sv
`include "pcg_map.svh"
package pcg_pkg;
  // ----------------------------------------------------------------
  // Power state of the device
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    st_active = 6'h01,
    st_idle = 6'h02,
    st_noise = 6'h04,
    st_pdown = 6'h08,
    st_psave = 6'h10,
    st_standby = 6'h20
  } pcg_state_t;

  // Same bit order as the gating register
  typedef struct packed {
    logic display;
    logic timer16;
    logic serial_periph;
    logic async_serial;
    logic converter;
  } pcg_gate_t;

  typedef struct packed {
    logic comparator_off;
    logic inbuf_sleep_off;
    logic main_osc_run;
    logic jtag_en;
    logic bod_en;
    logic vref_on;
  } pcg_policy_t;
endpackage

// ===== src/pcg_clk_enable.sv
`timescale 1ns/1ps
`default_nettype none
module pcg_clk_enable (
  // Power state and gating bits
  input wire pcg_pkg::pcg_state_t state,
  input wire pcg_pkg::pcg_gate_t gate,
  // Clock enables per peripheral
  output pcg_pkg::pcg_gate_t clk_en
);
  import pcg_pkg::*;

  logic io_run;
  logic adc_run;
  logic lcd_run;
  logic [4:0] run;
  logic [4:0] gate_v;
  logic [4:0] en_v;

  // Domains still clocked in each state
  assign io_run = (state == st_active) | (state == st_idle);
  assign adc_run = io_run | (state == st_noise);
  assign lcd_run = adc_run | (state == st_psave);
  assign run = {lcd_run, io_run, io_run, io_run, adc_run};
  assign gate_v = gate;

  genvar i;
  generate
    for (i = 0; i < 5; i++) begin : g_en
      // RULE14: gating acts on running clocks
      // RULE8: no reset on ungating, state resumes
      assign en_v[i] = run[i] & ~gate_v[i];
    end
  endgenerate

  assign clk_en = pcg_gate_t'(en_v);
endmodule // pcg_clk_enable
`default_nettype wire

// ===== src/pcg_power_policy.sv
`timescale 1ns/1ps
`default_nettype none
`include "pcg_map.svh"
module pcg_power_policy (
  // State and configuration
  input wire pcg_pkg::pcg_state_t state,
  input wire logic comparator_disable,
  input wire logic comparator_use_ref,
  input wire logic converter_enable,
  input wire logic test_port_disable,
  // Fuses
  input wire logic debug_enable_fuse,
  input wire logic test_port_enable_fuse,
  input wire logic [2:0] brownout_level_fuses,
  // Derived controls
  output pcg_pkg::pcg_policy_t pol
);
  import pcg_pkg::*;

  logic light;
  logic deep_dbg;

  assign light = (state == st_active) | (state == st_idle) |
                 (state == st_noise);
  assign deep_dbg = (state == st_pdown) | (state == st_psave);

  always_comb begin
    // RULE19: fuse and disable bit both gate the port
    pol.jtag_en = test_port_enable_fuse & ~test_port_disable;
    // RULE22: brown-out enable ignores sleep state
    pol.bod_en = brownout_level_fuses != `PCG_BOD_OFF;
    // RULE16: auto-off in deep sleep unless on reference
    pol.comparator_off = comparator_disable |
                         (~light & ~comparator_use_ref);
    // RULE17: both io and converter clocks stopped
    pol.inbuf_sleep_off = ~light;
    // RULE18: debug keeps main oscillator alive
    pol.main_osc_run = light | (state == st_standby) |
                       (deep_dbg & debug_enable_fuse & pol.jtag_en);
    // RULE21: reference on while any user is on
    pol.vref_on = pol.bod_en | converter_enable |
                  (~pol.comparator_off & comparator_use_ref);
  end
endmodule // pcg_power_policy
`default_nettype wire

// ===== src/pcg_top.sv
// Added by the designer: the APB register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "pcg_map.svh"
// Contract
// RULE1: gating register bits 7..5 always read back zero.
// RULE2: display gate bit stops the display controller clock.
// RULE3: timer gate bit stops the 16-bit timer; it resumes unchanged.
// RULE4: serial peripheral gate bit stops that module's clock.
// RULE5: async serial gate bit stops that module's clock.
// RULE6: converter gate bit stops the converter's clocked logic.
// RULE7: gated peripheral is frozen, its registers inaccessible.
// RULE8: clearing a gate bit resumes the module in its old state.
// RULE9: software disables a peripheral before gating it.
// RULE10: software disables and discharges the display before gating.
// RULE11: software disables the converter before gating it.
// RULE12: comparator cannot use converter mux while converter gated.
// RULE13: software reinitialises serial modules after ungating.
// RULE14: gating only matters in active and idle states; code also gates display in noise and power-save, converter in noise.
// RULE15: enable survives sleep; first conversion after turn-on is extended.
// RULE16: comparator auto-off in deep sleep unless using reference.
// RULE17: inputs off when io and converter clocks stop, except wake pins.
// RULE18: debug fuse keeps main clock in power-down and power-save; the code also requires the test port to be enabled.
// RULE19: disable bit or unprogrammed fuse turns the test port off.
// RULE20: test data out undriven unless port enabled and shifting.
// RULE21: reference on only while brown-out, comparator or converter need it.
// RULE22: fuse-enabled brown-out detector stays on in all sleep modes.
// RULE23: sleep codes: idle 000, noise reduction 001, power-down 010.
// RULE24: all gate bits zero after reset.
// RULE25: writes to gated peripheral dropped, reads return zero.
module pcg_top (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Core and fuses
  input wire logic cpu_sleeping,
  input wire logic debug_enable_fuse,
  input wire logic test_port_enable_fuse,
  input wire logic [2:0] brownout_level_fuses,
  // Test port
  input wire logic tap_shifting,
  input wire logic tap_tdo_data,
  output logic tdo_o,
  output logic tdo_oe,
  // Peripheral register access
  input wire pcg_pkg::pcg_gate_t io_sel,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_rdata_in,
  output pcg_pkg::pcg_gate_t io_wr_ok,
  output logic [7:0] io_rdata,
  // Converter
  input wire logic conv_start,
  output logic converter_enable,
  output logic extended_conv,
  // Clock and analog controls
  output pcg_pkg::pcg_gate_t periph_clk_en,
  output logic comparator_off,
  output logic comparator_mux_ok,
  output logic [7:0] input_off_a,
  output logic [7:0] input_off_b,
  output logic main_osc_run,
  output logic vref_on,
  output logic bod_en,
  output logic jtag_en
);
  import pcg_pkg::*;

  // ----------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------
  logic [7:0] gate_r;
  logic test_port_disable_r;
  logic [2:0] sleep_mode_select_r;
  logic [3:0] analog_r;
  logic [7:0] input_disable_a_r;
  logic [7:0] input_disable_b_r;
  logic [7:0] wake_mask_r;
  logic conv_en_prev_r;
  pcg_state_t state_r;
  pcg_state_t state_nxt;
  pcg_gate_t gate_s;
  pcg_gate_t clk_en_s;
  pcg_policy_t pol_s;
  logic [7:0] sel;
  logic [7:0] wsel;
  logic [31:0] rd_mux;
  logic conv_rise;

  function automatic logic [7:0] reg_dec(input logic [11:0] a);
    logic [7:0] s;
    s = 8'h00;
    s[0] = a == `PCG_OFF_GATE;
    s[1] = a == `PCG_OFF_SYSCTL;
    s[2] = a == `PCG_OFF_SLEEP;
    s[3] = a == `PCG_OFF_ANALOG;
    s[4] = a == `PCG_OFF_INDIS_A;
    s[5] = a == `PCG_OFF_INDIS_B;
    s[6] = a == `PCG_OFF_WAKE;
    s[7] = a == `PCG_OFF_STATUS;
    return s;
  endfunction

  assign gate_s = pcg_gate_t'(gate_r[4:0]);
  assign sel = reg_dec(paddr);
  // Write lands on the edge that samples pready high
  assign wsel = sel & {8{psel & penable & pready & pwrite}};
  assign conv_rise = analog_r[`PCG_ANA_CONV] & ~conv_en_prev_r;

  // ----------------------------------------------------------------
  // APB slave, one wait state
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel && penable && !pready) begin
      pready <= 1'b1;
      prdata <= pwrite ? 32'h0000_0000 : rd_mux;
      pslverr <= ~|sel;
    end else begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    // RULE1: reserved gate bits masked on read
    if (sel[0]) rd_mux[7:0] = gate_r & `PCG_GATE_MASK;
    if (sel[1]) rd_mux[`PCG_SYSCTL_TPD] = test_port_disable_r;
    if (sel[2]) rd_mux[2:0] = sleep_mode_select_r;
    if (sel[3]) rd_mux[3:0] = analog_r;
    if (sel[4]) rd_mux[7:0] = input_disable_a_r;
    if (sel[5]) rd_mux[7:0] = input_disable_b_r;
    if (sel[6]) rd_mux[7:0] = wake_mask_r;
    if (sel[7]) rd_mux[11:0] = {extended_conv, comparator_off,
      main_osc_run, bod_en, vref_on, jtag_en, 1'b0, periph_clk_en};
  end

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // RULE24: every peripheral clocked after reset
      gate_r <= `PCG_GATE_RST;
    end else if (wsel[0]) begin
      gate_r <= pwdata[7:0] & `PCG_GATE_MASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      test_port_disable_r <= 1'b0;
      sleep_mode_select_r <= `PCG_MODE_RST;
      analog_r <= `PCG_ANA_RST;
    end else begin
      if (wsel[1]) test_port_disable_r <= pwdata[`PCG_SYSCTL_TPD];
      if (wsel[2]) sleep_mode_select_r <= pwdata[2:0];
      if (wsel[3]) analog_r <= pwdata[3:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      input_disable_a_r <= `PCG_BYTE_RST;
      input_disable_b_r <= `PCG_BYTE_RST;
      wake_mask_r <= `PCG_BYTE_RST;
    end else begin
      if (wsel[4]) input_disable_a_r <= pwdata[7:0];
      if (wsel[5]) input_disable_b_r <= pwdata[7:0];
      if (wsel[6]) wake_mask_r <= pwdata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Power state
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = st_active;
    if (cpu_sleeping) begin
      // RULE23: sleep mode encoding
      unique case (sleep_mode_select_r)
        `PCG_MODE_IDLE: state_nxt = st_idle;
        `PCG_MODE_NOISE: state_nxt = st_noise;
        `PCG_MODE_PDOWN: state_nxt = st_pdown;
        `PCG_MODE_PSAVE: state_nxt = st_psave;
        `PCG_MODE_STANDBY: state_nxt = st_standby;
        // Reserved codes fall back to the deepest mode
        default: state_nxt = st_pdown;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= st_active;
    end else begin
      state_r <= state_nxt;
    end
  end

  pcg_clk_enable u_clk_enable (
    .state(state_r),
    .gate(gate_s),
    .clk_en(clk_en_s)
  );

  pcg_power_policy u_power_policy (
    .state(state_r),
    .comparator_disable(analog_r[`PCG_ANA_CMP_DIS]),
    .comparator_use_ref(analog_r[`PCG_ANA_CMP_REF]),
    .converter_enable(analog_r[`PCG_ANA_CONV]),
    .test_port_disable(test_port_disable_r),
    .debug_enable_fuse(debug_enable_fuse),
    .test_port_enable_fuse(test_port_enable_fuse),
    .brownout_level_fuses(brownout_level_fuses),
    .pol(pol_s)
  );

  // ----------------------------------------------------------------
  // Clock enables and analog controls
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      periph_clk_en <= pcg_gate_t'(5'h1F);
    end else begin
      // RULE2: display / RULE3: timer / RULE4: serial periph
      // RULE5: async serial / RULE6: converter
      periph_clk_en <= clk_en_s;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      comparator_off <= 1'b0;
      comparator_mux_ok <= 1'b0;
      main_osc_run <= 1'b1;
      vref_on <= 1'b0;
      bod_en <= 1'b0;
      jtag_en <= 1'b0;
      input_off_a <= 8'h00;
      input_off_b <= 8'h00;
    end else begin
      comparator_off <= pol_s.comparator_off;
      // RULE12: mux unusable with converter gated
      comparator_mux_ok <= analog_r[`PCG_ANA_CMP_MUX] & ~gate_s.converter;
      main_osc_run <= pol_s.main_osc_run;
      vref_on <= pol_s.vref_on;
      bod_en <= pol_s.bod_en;
      jtag_en <= pol_s.jtag_en;
      // RULE17: wake pins keep their buffers
      input_off_a <= input_disable_a_r |
                     ({8{pol_s.inbuf_sleep_off}} & ~wake_mask_r);
      input_off_b <= input_disable_b_r |
                     ({8{pol_s.inbuf_sleep_off}} & ~wake_mask_r);
    end
  end

  // ----------------------------------------------------------------
  // Test data out and peripheral access filter
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tdo_o <= 1'b0;
      tdo_oe <= 1'b0;
    end else begin
      // RULE20: released unless shifting
      tdo_oe <= pol_s.jtag_en & tap_shifting;
      tdo_o <= tap_tdo_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      io_wr_ok <= pcg_gate_t'(5'h00);
      io_rdata <= 8'h00;
    end else begin
      // RULE7: frozen module not reachable
      // RULE25: dropped writes, zero reads
      io_wr_ok <= pcg_gate_t'(io_sel & ~gate_s & {5{io_wr}});
      io_rdata <= (io_rd && |(io_sel & ~gate_s)) ? io_rdata_in : 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Converter enable and extended conversion
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      converter_enable <= 1'b0;
      conv_en_prev_r <= 1'b0;
      extended_conv <= 1'b1;
    end else begin
      // RULE15: enable not touched by sleep
      converter_enable <= analog_r[`PCG_ANA_CONV];
      conv_en_prev_r <= analog_r[`PCG_ANA_CONV];
      // RULE15: set wins over the clearing start
      if (conv_rise) extended_conv <= 1'b1;
      else if (conv_start) extended_conv <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_gate_reserved;
    psel && penable && !pready && !pwrite && paddr == `PCG_OFF_GATE
      |=> pready && prdata[31:5] == 27'h000_0000;
  endproperty
  a_gate_reserved: assert property (p_gate_reserved) // RULE1
    else $error("reserved gate bits read nonzero");

  property p_display_off;
    gate_r[4] |=> !periph_clk_en.display;
  endproperty
  a_display_off: assert property (p_display_off) // RULE2
    else $error("display clock runs while gated");

  sequence s_io_awake;
    state_r == st_active || state_r == st_idle;
  endsequence
  property p_timer_resume;
    s_io_awake ##0 !gate_r[3] |=> periph_clk_en.timer16;
  endproperty
  a_timer_resume: assert property (p_timer_resume) // RULE3
    else $error("timer clock not restored");

  property p_serial_off;
    gate_r[2] |=> !periph_clk_en.serial_periph;
  endproperty
  a_serial_off: assert property (p_serial_off) // RULE4
    else $error("serial periph clock runs while gated");

  property p_async_off;
    gate_r[1] |=> !periph_clk_en.async_serial;
  endproperty
  a_async_off: assert property (p_async_off) // RULE5
    else $error("async serial clock runs while gated");

  property p_conv_off;
    gate_r[0] |=> !periph_clk_en.converter && !comparator_mux_ok;
  endproperty
  a_conv_off: assert property (p_conv_off) // RULE6
    else $error("converter clock or mux active while gated");

  property p_access_block;
    (io_sel & gate_s) == io_sel && io_sel != 5'h00
      |=> io_wr_ok == 5'h00 && io_rdata == 8'h00;
  endproperty
  a_access_block: assert property (p_access_block) // RULE25
    else $error("gated peripheral was accessed");

  sequence s_conv_on;
    $rose(analog_r[`PCG_ANA_CONV]);
  endsequence
  property p_ext_conv;
    s_conv_on |=> extended_conv ##1 (extended_conv || $past(conv_start));
  endproperty
  a_ext_conv: assert property (p_ext_conv) // RULE15
    else $error("extended conversion not flagged");

  property p_deep_sleep;
    state_r == st_pdown |=> !periph_clk_en.timer16 &&
      !periph_clk_en.converter && !periph_clk_en.display;
  endproperty
  a_deep_sleep: assert property (p_deep_sleep) // RULE14
    else $error("clock running in power-down");

  property p_tdo_float;
    !(pol_s.jtag_en && tap_shifting) |=> !tdo_oe;
  endproperty
  a_tdo_float: assert property (p_tdo_float) // RULE20
    else $error("test data out driven while idle");

  property p_port_off;
    test_port_disable_r || !test_port_enable_fuse |=> !jtag_en && !tdo_oe;
  endproperty
  a_port_off: assert property (p_port_off) // RULE19
    else $error("test port enabled while disabled");

  property p_bod;
    brownout_level_fuses != `PCG_BOD_OFF |=> bod_en && vref_on;
  endproperty
  a_bod: assert property (p_bod) // RULE22
    else $error("brown-out detector or reference off");
endmodule // pcg_top
`default_nettype wire

// ===== tb/tb_pcg_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "pcg_map.svh"
module tb_pcg_top;
  import pcg_pkg::*;
  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pready, pslverr, tdo_o, tdo_oe;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, q, m;
  logic e, cpu_sleeping = 1'b0, debug_enable_fuse = 1'b0;
  logic test_port_enable_fuse = 1'b0, tap_shifting = 1'b0;
  logic tap_tdo_data = 1'b0, io_wr = 1'b0, io_rd = 1'b0, conv_start = 1'b0;
  logic [2:0] brownout_level_fuses = 3'h7;
  logic [7:0] io_rdata_in = 8'hA5, io_rdata, input_off_a, input_off_b;
  pcg_gate_t io_sel = '0, io_wr_ok, periph_clk_en;
  logic converter_enable, extended_conv, comparator_off, comparator_mux_ok;
  logic main_osc_run, vref_on, bod_en, jtag_en;
  int n_mismatch = 0, tests_run = 0;
  logic [2:0] md [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6};
  logic [4:0] ce [5] = '{5'h1F, 5'h11, 5'h00, 5'h10, 5'h00};
  // Mode index bits: osc runs, deep sleep
  logic [4:0] osc = 5'b10011, deep = 5'b11100;

  always #12.5 pclk = ~pclk;

  pcg_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cpu_sleeping(cpu_sleeping), .debug_enable_fuse(debug_enable_fuse),
    .test_port_enable_fuse(test_port_enable_fuse),
    .brownout_level_fuses(brownout_level_fuses),
    .tap_shifting(tap_shifting), .tap_tdo_data(tap_tdo_data),
    .tdo_o(tdo_o), .tdo_oe(tdo_oe), .io_sel(io_sel), .io_wr(io_wr),
    .io_rd(io_rd), .io_rdata_in(io_rdata_in), .io_wr_ok(io_wr_ok),
    .io_rdata(io_rdata), .conv_start(conv_start),
    .converter_enable(converter_enable), .extended_conv(extended_conv),
    .periph_clk_en(periph_clk_en), .comparator_off(comparator_off),
    .comparator_mux_ok(comparator_mux_ok), .input_off_a(input_off_a),
    .input_off_b(input_off_b), .main_osc_run(main_osc_run),
    .vref_on(vref_on), .bod_en(bod_en), .jtag_en(jtag_en));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic wrap_up;
    $display("Counts: %0d compares, %0d mismatches", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer; result left in q and e
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i == 20) begin
      n_mismatch++;
      wrap_up();
    end
  endtask

  // Controls land two edges after their cause; allow three
  task automatic st;
    repeat (3) @(posedge pclk);
    #1;
  endtask

  task automatic io(input logic [4:0] s, input logic wr,
                    input logic [7:0] exp);
    @(posedge pclk);
    io_sel <= s;
    io_wr <= wr;
    io_rd <= !wr;
    @(posedge pclk);
    #1;
    if (wr) chk(32'(io_wr_ok), 32'(exp));
    else chk(32'(io_rdata), 32'(exp));
    @(posedge pclk);
    io_sel <= '0;
    io_wr <= 1'b0;
    io_rd <= 1'b0;
  endtask

  task automatic sleep_in(input logic [2:0] m);
    apb(1'b1, `PCG_OFF_SLEEP, 32'(m));
    @(posedge pclk);
    cpu_sleeping <= 1'b1;
    st();
  endtask

  task automatic wake;
    @(posedge pclk);
    cpu_sleeping <= 1'b0;
    st();
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    st();
    chk(32'(periph_clk_en), 32'h0000_001F);
    apb(1'b0, `PCG_OFF_GATE, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    $display("test reset done");
    for (int b = 0; b < 5; b++) begin
      m = 32'h1 << b;
      apb(1'b1, `PCG_OFF_GATE, 32'h0000_00E0 | m);
      apb(1'b0, `PCG_OFF_GATE, 32'h0000_0000);
      chk(q, m);
      st();
      chk(32'(periph_clk_en), m ^ 32'h1F);
      io(m[4:0], 1'b0, 8'h00);
      io(m[4:0], 1'b1, 8'h00);
    end
    apb(1'b1, `PCG_OFF_GATE, 32'h0000_0000);
    st();
    io(5'h08, 1'b0, 8'hA5);
    io(5'h08, 1'b1, 8'h08);
    io(5'h04, 1'b1, 8'h04);
    $display("test gating done");
    apb(1'b1, `PCG_OFF_ANALOG, 32'h0000_0008);
    apb(1'b1, `PCG_OFF_GATE, 32'h0000_0001);
    st();
    chk(32'(comparator_mux_ok), 32'h0000_0000);
    apb(1'b1, `PCG_OFF_GATE, 32'h0000_0000);
    st();
    chk(32'(comparator_mux_ok), 32'h0000_0001);
    $display("test comparator mux done");
    @(posedge pclk);
    test_port_enable_fuse <= 1'b1;
    st();
    chk({jtag_en, tdo_oe}, 32'h0000_0002);
    @(posedge pclk);
    tap_shifting <= 1'b1;
    tap_tdo_data <= 1'b1;
    st();
    chk({tdo_oe, tdo_o}, 32'h0000_0003);
    apb(1'b1, `PCG_OFF_SYSCTL, 32'h0000_0001);
    st();
    chk({jtag_en, tdo_oe}, 32'h0000_0000);
    apb(1'b1, `PCG_OFF_SYSCTL, 32'h0000_0000);
    $display("test port done");
    apb(1'b1, `PCG_OFF_ANALOG, 32'h0000_0000);
    st();
    chk({bod_en, vref_on}, 32'h0000_0000);
    @(posedge pclk);
    brownout_level_fuses <= 3'h6;
    st();
    chk({bod_en, vref_on}, 32'h0000_0003);
    $display("test reference done");
    apb(1'b1, `PCG_OFF_GATE, 32'h0000_0008);
    sleep_in(`PCG_MODE_IDLE);
    chk(32'(periph_clk_en), 32'h0000_0017);
    wake();
    apb(1'b1, `PCG_OFF_GATE, 32'h0000_0000);
    apb(1'b1, `PCG_OFF_WAKE, 32'h0000_000F);
    for (int i = 0; i < 5; i++) begin
      sleep_in(md[i]);
      chk(32'(periph_clk_en), 32'(ce[i]));
      chk(32'(main_osc_run), 32'(osc[i]));
      chk(32'(comparator_off), 32'(deep[i]));
      chk(32'(input_off_a), deep[i] ? 32'hF0 : 32'h00);
      chk(32'(input_off_b), deep[i] ? 32'hF0 : 32'h00);
      chk(32'(bod_en), 32'h0000_0001);
      wake();
    end
    @(posedge pclk);
    debug_enable_fuse <= 1'b1;
    sleep_in(`PCG_MODE_PDOWN);
    chk(32'(main_osc_run), 32'h0000_0001);
    apb(1'b1, `PCG_OFF_SYSCTL, 32'h0000_0001);
    st();
    chk(32'(main_osc_run), 32'h0000_0000);
    wake();
    apb(1'b1, `PCG_OFF_ANALOG, 32'h0000_0004);
    sleep_in(`PCG_MODE_PDOWN);
    chk({comparator_off, vref_on}, 32'h0000_0001);
    wake();
    $display("test sleep modes done");
    apb(1'b1, `PCG_OFF_ANALOG, 32'h0000_0001);
    st();
    chk({converter_enable, extended_conv}, 32'h0000_0003);
    @(posedge pclk);
    conv_start <= 1'b1;
    @(posedge pclk);
    conv_start <= 1'b0;
    st();
    chk(32'(extended_conv), 32'h0000_0000);
    sleep_in(`PCG_MODE_PDOWN);
    chk({converter_enable, vref_on}, 32'h0000_0003);
    wake();
    apb(1'b1, `PCG_OFF_ANALOG, 32'h0000_0000);
    apb(1'b1, `PCG_OFF_ANALOG, 32'h0000_0001);
    st();
    chk(32'(extended_conv), 32'h0000_0001);
    $display("test converter done");
    apb(1'b0, 12'h020, 32'h0000_0000);
    chk({q[30:0], e}, 32'h0000_0001);
    apb(1'b1, `PCG_OFF_STATUS, 32'hFFFF_FFFF);
    apb(1'b0, `PCG_OFF_STATUS, 32'h0000_0000);
    chk({e, q[4:0]}, 32'h0000_001F);
    $display("test bus errors done");
    wrap_up();
  end
endmodule // tb_pcg_top
`default_nettype wire
